/* dpr_host.sv */
// host controller driving one port of the dual-port memory
// assumes busy arrives synchronous with i_clk and pulled up off chip
`timescale 1ns/1ns
`include "dpr_params.svh"
module dpr_host #(
  parameter int ADDR_W   = `DPR_ADDR_W,
  parameter int DATA_W   = `DPR_DATA_W,
  parameter int SETTLE   = `DPR_SETTLE_CYC,
  parameter int FLOW     = `DPR_FLOW_CYC,
  parameter int ACCESS   = `DPR_ACCESS_CYC,
  parameter int WPULSE   = `DPR_WPULSE_CYC
) (
  // clock and reset
  input  wire logic                 i_clk,
  input  wire logic                 i_rst_n,
  // user request
  input  wire logic                 i_req_valid,
  output logic                      o_req_ready,
  input  wire dpr_pkg::dpr_op_t     i_req_op,
  input  wire logic [ADDR_W-1:0]    i_req_addr,
  input  wire logic [DATA_W-1:0]    i_req_wdata,
  // user answer
  output logic                      o_rsp_valid,
  output logic [DATA_W-1:0]         o_rsp_rdata,
  output logic                      o_rsp_retried,
  // memory port pins
  output logic [ADDR_W-1:0]         o_mem_addr,
  output logic                      o_mem_select_n,
  output logic                      o_mem_oe_n,
  output logic                      o_lower_byte_write_strobe_n,
  output logic                      o_upper_byte_write_strobe_n,
  input  wire logic [DATA_W-1:0]    i_mem_dq,
  output logic [DATA_W-1:0]         o_mem_dq,
  output logic [DATA_W-1:0]         o_mem_dq_oe,
  input  wire logic                 i_mem_busy_n
);
  import dpr_pkg::*;

  localparam int CW = 4;
  localparam int LANE = `DPR_LANE_W;

  // elaboration checks for the two-lane data width and for values the counter cannot hold
  initial begin
    if (DATA_W != 2 * LANE) $error("dpr_host: data width must be two byte lanes");
    if (SETTLE < 1 || SETTLE > 15) $error("dpr_host: SETTLE out of range");
    if (FLOW < 1 || FLOW > 15) $error("dpr_host: FLOW out of range");
    if (ACCESS < 1 || ACCESS > 15) $error("dpr_host: ACCESS out of range");
    if (WPULSE < 1 || WPULSE > 15) $error("dpr_host: WPULSE out of range");
  end

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETTLE,
    ST_ACCESS,
    ST_WAIT_BUSY,
    ST_EXTEND,
    ST_END
  } dpr_state_t;

  dpr_state_t      state_q;
  dpr_op_t         op_q;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] wdata_q;
  logic [DATA_W-1:0] rdata_q;
  logic            rsp_valid_q;
  logic            retried_q;
  logic            load;
  logic [CW-1:0]   load_val;
  logic            cnt_done;
  logic            is_write;
  logic            wr_lo;
  logic            wr_hi;
  logic            busy;

  assign is_write = (op_q != DPR_OP_READ);
  assign wr_lo    = (op_q == DPR_OP_WRITE_LO) || (op_q == DPR_OP_WRITE_BOTH);
  assign wr_hi    = (op_q == DPR_OP_WRITE_HI) || (op_q == DPR_OP_WRITE_BOTH);
  assign busy     = !i_mem_busy_n;

  dpr_wait_cnt #(
    .W (CW)
  ) u_cnt (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_load  (load),
    .i_count (load_val),
    .o_done  (cnt_done)
  );

  // counter loads when a timed phase begins
  always_comb begin
    load     = 1'b0;
    load_val = '0;
    case (state_q)
      ST_IDLE: begin
        if (i_req_valid) begin
          load     = 1'b1;
          load_val = CW'(SETTLE);
        end
      end
      ST_SETTLE: begin
        if (cnt_done && !busy) begin
          load     = 1'b1;
          // a read may race a far-side write, so cover the flow-through too
          load_val = is_write ? CW'(WPULSE) : CW'(ACCESS + FLOW);
        end
      end
      // full repeat after busy
      // loading here rather than in the wait keeps the repeated phase its full length
      ST_EXTEND: begin
        load     = 1'b1;
        load_val = is_write ? CW'(WPULSE) : CW'(ACCESS + FLOW);
      end
      default: begin
        load     = 1'b0;
        load_val = '0;
      end
    endcase
  end

  // main sequence
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE:     if (i_req_valid) state_q <= ST_SETTLE;
        ST_SETTLE:   if (cnt_done) state_q <= busy ? ST_WAIT_BUSY : ST_ACCESS;
        ST_ACCESS: begin
          if (busy) state_q <= ST_WAIT_BUSY;
          else if (cnt_done) state_q <= ST_END;
        end
        ST_WAIT_BUSY: if (!busy) state_q <= ST_EXTEND;
        ST_EXTEND:   state_q <= ST_ACCESS;
        ST_END:      state_q <= ST_IDLE;
        default:     state_q <= ST_IDLE;
      endcase
    end
  end

  // request capture
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      op_q    <= DPR_OP_READ;
      addr_q  <= '0;
      wdata_q <= '0;
    end else if (state_q == ST_IDLE && i_req_valid) begin
      op_q    <= i_req_op;
      addr_q  <= i_req_addr;
      wdata_q <= i_req_wdata;
    end
  end

  // retry marker for the answer
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      retried_q <= 1'b0;
    end else if (state_q == ST_IDLE) begin
      retried_q <= 1'b0;
    end else if (state_q == ST_WAIT_BUSY) begin
      retried_q <= 1'b1;
    end
  end

  // sample read data after flow-through time
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_q     <= '0;
      rsp_valid_q <= 1'b0;
    end else begin
      rsp_valid_q <= (state_q == ST_END);
      if (state_q == ST_ACCESS && cnt_done && !busy && !is_write) begin
        rdata_q <= i_mem_dq;
      end else if (state_q == ST_ACCESS && cnt_done && !busy) begin
        // read the lane that is not being written
        rdata_q <= wr_lo ? (wr_hi ? '0 : {i_mem_dq[DATA_W-1:LANE], {LANE{1'b0}}})
                         : {{LANE{1'b0}}, i_mem_dq[LANE-1:0]};
      end
    end
  end

  // pin drive; addr held through whole cycle
  logic active;
  logic strobe_on;
  assign active    = (state_q != ST_IDLE);
  // strobe rises at the end of ST_ACCESS, ending the write
  assign strobe_on = (state_q == ST_ACCESS) && is_write;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_mem_addr                  <= '0;
      o_mem_select_n              <= 1'b1;
      o_mem_oe_n                  <= 1'b1;
      o_lower_byte_write_strobe_n <= 1'b1;
      o_upper_byte_write_strobe_n <= 1'b1;
      o_mem_dq                    <= '0;
      o_mem_dq_oe                 <= '0;
    end else begin
      o_mem_addr     <= (state_q == ST_IDLE) ? i_req_addr : addr_q;
      o_mem_select_n <= !(active || (state_q == ST_IDLE && i_req_valid));
      // read enables outputs; partial write reads other lane
      o_mem_oe_n     <= !(active && op_q != DPR_OP_WRITE_BOTH);
      o_lower_byte_write_strobe_n <= !(strobe_on && wr_lo && !busy && !cnt_done);
      o_upper_byte_write_strobe_n <= !(strobe_on && wr_hi && !busy && !cnt_done);
      o_mem_dq    <= wdata_q;
      o_mem_dq_oe <= {{LANE{strobe_on && wr_hi}}, {LANE{strobe_on && wr_lo}}};
    end
  end

  assign o_req_ready   = (state_q == ST_IDLE);
  assign o_rsp_valid   = rsp_valid_q;
  assign o_rsp_rdata   = rdata_q;
  assign o_rsp_retried = retried_q;
endmodule

/* dpr_params.svh */
// timing and field constants for the dual-port memory host controller
// assumes a 10 MHz system clock driving the memory pins directly
// Notes on behaviour
// - read needs select low, strobes high, output enable low; else bus floats
// - data written by far port is valid only after flow-through delay
// - host waits for busy to settle before writing slaves
// - host treats busy as not-ready, then repeats the whole access phase once busy clears
`ifndef DPR_PARAMS_SVH
`define DPR_PARAMS_SVH

`define DPR_CLK_PERIOD_NS   100
// busy settle, worst grade of match and select delays
`define DPR_FLAG_DELAY_FROM_MATCH_NS  50
`define DPR_FLAG_DELAY_FROM_SELECT_NS 35
// flow-through data delay for contending read
`define DPR_FLOW_THROUGH_DELAY_NS     55
// access and write pulse least times
`define DPR_ACCESS_NS      55
`define DPR_WRITE_PULSE_NS 35
`define DPR_CEIL_CYC(ns) (((ns) + `DPR_CLK_PERIOD_NS - 1) / `DPR_CLK_PERIOD_NS)
`define DPR_SETTLE_CYC  `DPR_CEIL_CYC(`DPR_FLAG_DELAY_FROM_MATCH_NS)
`define DPR_FLOW_CYC    `DPR_CEIL_CYC(`DPR_FLOW_THROUGH_DELAY_NS)
`define DPR_ACCESS_CYC  `DPR_CEIL_CYC(`DPR_ACCESS_NS)
`define DPR_WPULSE_CYC  `DPR_CEIL_CYC(`DPR_WRITE_PULSE_NS)
`define DPR_ADDR_W  11
`define DPR_DATA_W  16
`define DPR_LANE_W  8

`endif

/* dpr_pkg.sv */
// types shared by the dual-port memory host controller
// assumes the params header is on the include path
package dpr_pkg;
  typedef enum logic [1:0] {
    DPR_OP_READ,
    DPR_OP_WRITE_LO,
    DPR_OP_WRITE_HI,
    DPR_OP_WRITE_BOTH
  } dpr_op_t;
endpackage

/* dpr_wait_cnt.sv */
// down-counter used for every timed phase of the memory cycle
// assumes a load pulse and a single synchronous clock
`timescale 1ns/1ns
module dpr_wait_cnt #(
  parameter int W = 4
) (
  // clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  // control
  input  wire logic         i_load,
  input  wire logic [W-1:0] i_count,
  // status
  output logic              o_done
);
  logic [W-1:0] cnt_q;

  initial begin
    if (W < 1) $error("dpr_wait_cnt: W must be at least 1");
  end

  // load wins over the count so a phase always starts clean
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q <= '0;
    end else if (i_load) begin
      cnt_q <= i_count;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  // done ignores load, so a caller may load on done without a combinational loop
  assign o_done = (cnt_q == '0);
endmodule

/* dpr_host_sva.sv */
// assertions on the memory-side pins of the port host
// assumes binding into dpr_host; settle count handed on by the bind
`timescale 1ns/1ns
module dpr_host_sva #(
  parameter int DATA_W = 16,
  parameter int SETTLE = 1
) (
  // clock and reset
  input wire logic              i_clk,
  input wire logic              i_rst_n,
  // memory pins
  input wire logic              o_mem_select_n,
  input wire logic              o_mem_oe_n,
  input wire logic              o_lower_byte_write_strobe_n,
  input wire logic              o_upper_byte_write_strobe_n,
  input wire logic [DATA_W-1:0] o_mem_dq_oe,
  input wire logic              i_mem_busy_n
);
  logic [3:0] sel_cnt_q;
  logic       strb_hi;
  assign strb_hi = o_lower_byte_write_strobe_n & o_upper_byte_write_strobe_n;
  // cycles spent selected; saturates so a long busy wait cannot wrap to zero
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) sel_cnt_q <= 4'h0;
    else if (o_mem_select_n) sel_cnt_q <= 4'h0;
    else if (sel_cnt_q != 4'hf) sel_cnt_q <= sel_cnt_q + 4'h1;
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  property p_settle_first; !strb_hi |-> sel_cnt_q > SETTLE; endproperty
  a_settle_first: assert property (p_settle_first)
    else $error("strobe low before busy settled");
  property p_busy_hold; !i_mem_busy_n |=> strb_hi; endproperty
  a_busy_hold: assert property (p_busy_hold)
    else $error("strobe low while busy");
  property p_read_float; !o_mem_oe_n && strb_hi && $past(strb_hi) |-> o_mem_dq_oe == '0;
  endproperty
  a_read_float: assert property (p_read_float)
    else $error("host drives data during read");
  property p_oe_sel; !o_mem_oe_n |-> !o_mem_select_n; endproperty
  a_oe_sel: assert property (p_oe_sel)
    else $error("output enable without select");
endmodule

bind dpr_host dpr_host_sva #(.DATA_W(DATA_W), .SETTLE(SETTLE)) u_sva (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .o_mem_select_n(o_mem_select_n),
  .o_mem_oe_n(o_mem_oe_n), .o_lower_byte_write_strobe_n(o_lower_byte_write_strobe_n),
  .o_upper_byte_write_strobe_n(o_upper_byte_write_strobe_n),
  .o_mem_dq_oe(o_mem_dq_oe), .i_mem_busy_n(i_mem_busy_n));

/* dpr_mem_model.sv */
// behavioural model of one port of the dual-port memory
// assumes the bench plays the far port through i_contend and i_far_*
`timescale 1ns/1ns
module dpr_mem_model (
  // port pins
  input  wire logic [10:0] i_addr,
  input  wire logic        i_sel_n,
  input  wire logic        i_oe_n,
  input  wire logic        i_lo_n,
  input  wire logic        i_hi_n,
  input  wire logic [15:0] i_dq,
  output logic      [15:0] o_dq,
  output logic      [15:0] o_dq_en,
  output logic             o_busy_n,
  // far port stand-in
  input  wire logic        i_contend,
  input  wire logic        i_far_we,
  input  wire logic [10:0] i_far_addr,
  input  wire logic [15:0] i_far_data
);
  logic [15:0] mem [0:2047];
  logic [7:0]  ev = 8'h00;
  wire  [7:0]  ev_d;
  // flow-through delay: data only trusted 55 ns after the last change
  always @(i_addr or i_sel_n or i_oe_n or posedge i_far_we) ev = ev + 8'h01;
  assign #55 ev_d = ev;
  assign o_dq = (ev_d == ev) ? mem[i_addr] : ~mem[i_addr];
  // lane output enables
  // lanes turn on just after a strobe rises, so the capture still sees host data
  assign #1 o_dq_en = {{8{!i_sel_n && !i_oe_n && i_hi_n}},
                       {8{!i_sel_n && !i_oe_n && i_lo_n}}};
  assign #35 o_busy_n = !(i_contend && !i_sel_n);
  always @(posedge i_lo_n or posedge i_sel_n)
    if ((!i_lo_n || !i_sel_n) && o_busy_n) mem[i_addr][7:0] = i_dq[7:0];
  always @(posedge i_hi_n or posedge i_sel_n)
    if ((!i_hi_n || !i_sel_n) && o_busy_n) mem[i_addr][15:8] = i_dq[15:8];
  always @(posedge i_far_we) mem[i_far_addr] = i_far_data;
endmodule

/* dpr_host_tb_top.sv */
// self-checking bench for the memory port host
// assumes the memory model stands in for the device and its far port
`timescale 1ns/1ns
module dpr_host_tb_top;
  import dpr_pkg::*;
  logic i_clk = 1'b0, i_rst_n = 1'b0, i_req_valid = 1'b0, contend = 1'b0, far_we = 1'b0;
  logic [10:0] req_addr = 11'h000, far_addr = 11'h000, mem_addr;
  logic [15:0] req_wdata = 16'h0000, far_data = 16'h0000, rsp_rdata, host_dq, host_oe;
  logic [15:0] mdq, men, dq_w, bus_q = 16'h0000;
  logic        o_req_ready, o_rsp_valid, rsp_retried, sel_n, oe_n, lo_n, hi_n, busy_n;
  dpr_op_t     req_op = DPR_OP_READ;
  int          n_fail = 0, n_checks = 0;
  always #50 i_clk = ~i_clk;
  // released lines show the inverse of their last level, never a lucky match
  assign dq_w = (mdq & men) | (host_dq & host_oe & ~men) | (~bus_q & ~men & ~host_oe);
  always @(posedge i_clk) bus_q <= dq_w;
  dpr_host dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_req_valid(i_req_valid),
    .o_req_ready(o_req_ready), .i_req_op(req_op), .i_req_addr(req_addr),
    .i_req_wdata(req_wdata), .o_rsp_valid(o_rsp_valid), .o_rsp_rdata(rsp_rdata),
    .o_rsp_retried(rsp_retried), .o_mem_addr(mem_addr), .o_mem_select_n(sel_n),
    .o_mem_oe_n(oe_n), .o_lower_byte_write_strobe_n(lo_n),
    .o_upper_byte_write_strobe_n(hi_n), .i_mem_dq(dq_w), .o_mem_dq(host_dq),
    .o_mem_dq_oe(host_oe), .i_mem_busy_n(busy_n));
  dpr_mem_model u_mem (.i_addr(mem_addr), .i_sel_n(sel_n), .i_oe_n(oe_n), .i_lo_n(lo_n),
    .i_hi_n(hi_n), .i_dq(dq_w), .o_dq(mdq), .o_dq_en(men), .o_busy_n(busy_n),
    .i_contend(contend), .i_far_we(far_we), .i_far_addr(far_addr), .i_far_data(far_data));
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one request, waits for the answer and judges data and retry flag
  task automatic req(input dpr_op_t op, input logic [10:0] a, input logic [15:0] d,
                     input logic [15:0] exp_d, input logic exp_r);
    int k;
    k = 0;
    while (o_req_ready !== 1'b1 && k < 60) begin
      @(negedge i_clk);
      k++;
    end
    req_op = op;
    req_addr = a;
    req_wdata = d;
    i_req_valid = 1'b1;
    @(negedge i_clk);
    i_req_valid = 1'b0;
    while (o_rsp_valid !== 1'b1 && k < 60) begin
      @(negedge i_clk);
      k++;
    end
    chk({o_rsp_valid, rsp_retried, rsp_rdata}, {1'b1, exp_r, exp_d});
  endtask
  task automatic t_full();
    req(DPR_OP_WRITE_BOTH, 11'h7ff, 16'hc35a, 16'h0000, 1'b0);
    req(DPR_OP_WRITE_BOTH, 11'h000, 16'h1234, 16'h0000, 1'b0);
    req(DPR_OP_READ, 11'h7ff, 16'h0000, 16'hc35a, 1'b0);
  endtask
  task automatic t_lanes();
    req(DPR_OP_WRITE_BOTH, 11'h005, 16'haaaa, 16'h0000, 1'b0);
    req(DPR_OP_WRITE_LO, 11'h005, 16'h0034, 16'haa00, 1'b0);
    req(DPR_OP_WRITE_HI, 11'h005, 16'h5600, 16'h0034, 1'b0);
    req(DPR_OP_READ, 11'h005, 16'h0000, 16'h5634, 1'b0);
  endtask
  task automatic t_busy();
    req(DPR_OP_WRITE_BOTH, 11'h010, 16'h1111, 16'h0000, 1'b0);
    contend = 1'b1;
    fork
      req(DPR_OP_WRITE_BOTH, 11'h010, 16'hbeef, 16'h0000, 1'b1);
      begin
        repeat (8) @(negedge i_clk);
        chk({2'b00, u_mem.mem[16]}, 18'h01111);
        contend = 1'b0;
      end
    join
    req(DPR_OP_READ, 11'h010, 16'h0000, 16'hbeef, 1'b0);
  endtask
  task automatic t_flow();
    req(DPR_OP_WRITE_BOTH, 11'h020, 16'h0000, 16'h0000, 1'b0);
    fork
      req(DPR_OP_READ, 11'h020, 16'h0000, 16'h7e81, 1'b0);
      begin
        repeat (2) @(posedge i_clk);
        #10 far_addr = 11'h020;
        far_data = 16'h7e81;
        far_we = 1'b1;
      end
    join
    far_we = 1'b0;
  endtask
  task automatic complete_run();
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // main sequence after sixteen cycles of reset
  initial begin
    repeat (16) @(negedge i_clk);
    i_rst_n = 1'b1;
    @(negedge i_clk);
    t_full();
    t_lanes();
    t_busy();
    t_flow();
    complete_run();
  end
  // watchdog well beyond the hundred-odd cycles the tests need
  initial begin
    #400000;
    n_fail++;
    complete_run();
  end
endmodule
